// *** pm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
//Contract
// - One open-drain alert for diagnostics or conversions
// - Compare results to thresholds, set flags, alert
// - Shunt thresholds reset 0x7FFF and 0x8000, signed
// - Bus thresholds reset 0x7FFF and 0x0000
// - Temperature 0xFFFF and power 0x7FFF limits
// - Diagnostic register shows every status flag
// - Latched alert held until diagnostic read
// - Conversion-ready enable asserts alert on completion
// - Conversion done flag set on every completion
// - Averaged selection compares averaged results only
// - Alert active low; polarity bit makes high
// - Overflow flag readable, never drives alert
// - Trim memory flag reads one, no alert
// - Shutdown stops conversions, registers stay accessible
// - Shutdown until mode write requests conversion or software reset restores continuous mode
// - Triggered conversion returns to shutdown itself
// - Power-on or software reset restores defaults
// - Bus target only, open-drain, never initiates
// - Fast or high-speed rates, MSB first
// - Address 100 plus two two-bit pin codes
// - Address pins sampled at every bus communication
// - Done flag cleared by non-shutdown mode write, diagnostic read
// - Write is pointer then two acknowledged bytes
module pm_top
#(
	parameter logic [15:0] ID_VALUE = 16'h1234 // Arbitrary value
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_scl,
	output logic o_scl_o,
	output logic o_scl_oe_n,
	input wire logic i_sda,
	output logic o_sda_o,
	output logic o_sda_oe_n,
	output logic o_alert_o,
	output logic o_alert_oe_n,
	input wire logic [1:0] i_addr_sel_high_pin,
	input wire logic [1:0] i_addr_sel_low_pin,
	input wire logic i_sample_stb,
	input wire logic i_avg_done,
	input wire logic [15:0] i_shunt,
	input wire logic [15:0] i_bus,
	input wire logic [15:0] i_temp,
	input wire logic [15:0] i_current,
	input wire logic [15:0] i_power,
	input wire logic i_arith_overflow,
	input wire logic i_trim_ok,
	output logic o_conv_start,
	output logic o_conv_active,
	output logic [2:0] o_conv_channels
);
	//**********************************************************
	// State
	//**********************************************************
	typedef struct packed {
		logic [15:0] config_reg;
		logic [15:0] converter_setup_reg;
		logic [15:0] shunt_high_threshold;
		logic [15:0] shunt_low_threshold;
		logic [15:0] bus_high_threshold;
		logic [15:0] bus_low_threshold;
		logic [15:0] temp_threshold;
		logic [15:0] wattage_threshold;
		logic alert_latch_en;
		logic conv_ready_alert_en;
		logic alert_on_averaged_sel;
		logic alert_active_high_sel;
		logic shunt_high_flag;
		logic shunt_low_flag;
		logic bus_high_flag;
		logic bus_low_flag;
		logic die_heat_flag;
		logic power_over_limit_flag;
		logic arith_overflow_flag;
		logic conv_done_flag;
		pm_pkg::pm_conv_e conv_st;
	} pm_regs_s;

	typedef struct packed {
		pm_regs_s regs;
		pm_pkg::pm_bus_e bus_st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic rw;
		logic [1:0] byte_idx;
		logic [7:0] ptr;
		logic [7:0] msb;
		logic [15:0] tx;
		logic sda_drive;
		logic [3:0] pins_meta;
		logic [3:0] pins_s;
		logic [3:0] pins_bus;
		logic conv_start;
		logic alert_drive;
	} pm_state_s;

	localparam pm_regs_s RST_REGS = '{
		config_reg: pm_pkg::RST_CONFIG,
		converter_setup_reg: pm_pkg::RST_ADC,
		shunt_high_threshold: pm_pkg::RST_SHUNT_HIGH,
		shunt_low_threshold: pm_pkg::RST_SHUNT_LOW,
		bus_high_threshold: pm_pkg::RST_BUS_HIGH,
		bus_low_threshold: pm_pkg::RST_BUS_LOW,
		temp_threshold: pm_pkg::RST_TEMP_LIMIT,
		wattage_threshold: pm_pkg::RST_WATT_LIMIT,
		conv_st: pm_pkg::PM_CONV_CONT,
		default: '0
	};
	localparam pm_state_s RST_STATE = '{
		regs: RST_REGS,
		bus_st: pm_pkg::PM_BUS_IDLE,
		default: '0
	};

	pm_state_s r;
	pm_state_s next_r;
	logic rst_meta_b;
	logic rst_sync_b;
	pm_link_if link ();
	localparam int MODE_BITS = pm_pkg::MODE_W;

	//**********************************************************
	// Reset release and bus front end
	//**********************************************************
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	pm_bus_phy u_phy (
		.i_clk_sys(i_clk_sys),
		.i_rst_sync_b(rst_sync_b),
		.i_scl(i_scl),
		.i_sda(i_sda),
		.link(link)
	);

	//**********************************************************
	// Helpers
	//**********************************************************
	function automatic logic [15:0] diag_word(input pm_regs_s g,
		input logic trim_ok);
		logic [15:0] w;
		w = '0;
		w[pm_pkg::DG_LATCH] = g.alert_latch_en;
		w[pm_pkg::DG_CONV_READY_ALERT_EN] = g.conv_ready_alert_en;
		w[pm_pkg::DG_SLOW] = g.alert_on_averaged_sel;
		w[pm_pkg::DG_ALERT_ACTIVE_HIGH_SEL] = g.alert_active_high_sel;
		w[pm_pkg::DG_ARITH_OVERFLOW_FLAG] = g.arith_overflow_flag;
		w[pm_pkg::DG_TEMP] = g.die_heat_flag;
		w[pm_pkg::DG_SHUNT_HI] = g.shunt_high_flag;
		w[pm_pkg::DG_SHUNT_LO] = g.shunt_low_flag;
		w[pm_pkg::DG_BUS_HI] = g.bus_high_flag;
		w[pm_pkg::DG_BUS_LO] = g.bus_low_flag;
		w[pm_pkg::DG_POWER] = g.power_over_limit_flag;
		w[pm_pkg::DG_CONV_DONE_FLAG] = g.conv_done_flag;
		w[pm_pkg::DG_MEMOK] = trim_ok;
		return w;
	endfunction

	function automatic logic sgt(input logic [15:0] a,
		input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction

	logic [15:0] rd_word;
	always_comb
	begin
		unique case (r.ptr)
			pm_pkg::REG_CONFIG: rd_word = r.regs.config_reg;
			pm_pkg::REG_ADC: rd_word = r.regs.converter_setup_reg;
			pm_pkg::REG_VSHUNT: rd_word = i_shunt;
			pm_pkg::REG_VBUS: rd_word = i_bus;
			pm_pkg::REG_DIETEMP: rd_word = i_temp;
			pm_pkg::REG_CURRENT: rd_word = i_current;
			pm_pkg::REG_POWER: rd_word = i_power;
			pm_pkg::REG_DIAG: rd_word = diag_word(r.regs, i_trim_ok);
			pm_pkg::REG_SHUNT_HIGH: rd_word = r.regs.shunt_high_threshold;
			pm_pkg::REG_SHUNT_LOW: rd_word = r.regs.shunt_low_threshold;
			pm_pkg::REG_BUS_HIGH: rd_word = r.regs.bus_high_threshold;
			pm_pkg::REG_BUS_LOW: rd_word = r.regs.bus_low_threshold;
			pm_pkg::REG_TEMP_LIMIT: rd_word = r.regs.temp_threshold;
			pm_pkg::REG_WATT_LIMIT: rd_word = r.regs.wattage_threshold;
			pm_pkg::REG_ID: rd_word = ID_VALUE;
			default: rd_word = '0;
		endcase
	end

	//**********************************************************
	// Next state
	//**********************************************************
	always_comb
	begin
		logic diag_rd;
		logic soft_rst;
		logic wr_commit;
		logic [15:0] wd;
		logic [MODE_BITS-1:0] mode;
		logic cmp;
		logic hit_sh;
		logic hit_sl;
		logic hit_bh;
		logic hit_bl;
		logic hit_t;
		logic hit_p;
		logic any_diag;
		logic active;
		diag_rd = 1'b0;
		soft_rst = 1'b0;
		wr_commit = 1'b0;
		wd = '0;
		mode = '0;
		any_diag = 1'b0;
		active = 1'b0;
		cmp = r.regs.alert_on_averaged_sel ? i_avg_done : i_sample_stb;
		hit_sh = sgt(i_shunt, r.regs.shunt_high_threshold);
		hit_sl = sgt(r.regs.shunt_low_threshold, i_shunt);
		hit_bh = sgt(i_bus, r.regs.bus_high_threshold);
		hit_bl = sgt(r.regs.bus_low_threshold, i_bus);
		hit_t = ~i_temp[15] & (i_temp > r.regs.temp_threshold);
		hit_p = i_power > r.regs.wattage_threshold;
		next_r = r;
		next_r.conv_start = 1'b0;
		next_r.pins_meta = {i_addr_sel_high_pin, i_addr_sel_low_pin};
		next_r.pins_s = r.pins_meta;

		// Target only: this FSM answers, never starts a transfer
		// target state machine
		if (link.start)
		begin
			next_r.bus_st = pm_pkg::PM_BUS_ADDR;
			next_r.cnt = '0;
			next_r.byte_idx = '0;
			next_r.sda_drive = 1'b0;
			next_r.pins_bus = r.pins_s;
		end
		else if (link.stop)
		begin
			next_r.bus_st = pm_pkg::PM_BUS_IDLE;
			next_r.sda_drive = 1'b0;
		end
		else
		begin
			unique case (r.bus_st)
				pm_pkg::PM_BUS_IDLE: ;
				pm_pkg::PM_BUS_ADDR, pm_pkg::PM_BUS_WR:
				begin
					if (link.scl_rise)
					begin
						next_r.shift = {r.shift[6:0], link.sda};
						next_r.cnt = r.cnt + 4'h1;
					end
					else if (link.scl_fall && r.cnt == pm_pkg::BITS_PER_BYTE)
					begin
						if (r.bus_st == pm_pkg::PM_BUS_WR)
						begin
							wr_commit = 1'b1;
							next_r.rw = 1'b0;
							next_r.sda_drive = 1'b1;
							next_r.bus_st = pm_pkg::PM_BUS_ACK;
						end
						else if (r.shift[7:1] == {pm_pkg::ADDR_BASE, r.pins_bus})
						begin
							next_r.rw = r.shift[0];
							next_r.sda_drive = 1'b1;
							next_r.bus_st = pm_pkg::PM_BUS_ACK;
						end
						else
							next_r.bus_st = pm_pkg::PM_BUS_IDLE;
					end
				end
				pm_pkg::PM_BUS_ACK:
				begin
					if (link.scl_fall)
					begin
						next_r.cnt = '0;
						if (r.rw)
						begin
							next_r.tx = rd_word;
							next_r.sda_drive = ~rd_word[15];
							diag_rd = (r.ptr == pm_pkg::REG_DIAG);
							next_r.bus_st = pm_pkg::PM_BUS_RD;
						end
						else
						begin
							next_r.sda_drive = 1'b0;
							next_r.bus_st = pm_pkg::PM_BUS_WR;
						end
					end
				end
				pm_pkg::PM_BUS_RD:
				begin
					if (link.scl_rise)
						next_r.cnt = r.cnt + 4'h1;
					else if (link.scl_fall)
					begin
						next_r.tx = {r.tx[14:0], 1'b0};
						if (r.cnt == pm_pkg::BITS_PER_BYTE)
						begin
							next_r.sda_drive = 1'b0;
							next_r.bus_st = pm_pkg::PM_BUS_RACK;
						end
						else
							next_r.sda_drive = ~r.tx[14];
					end
				end
				pm_pkg::PM_BUS_RACK:
				begin
					if (link.scl_rise)
						next_r.bus_st = link.sda ? pm_pkg::PM_BUS_IDLE
							: pm_pkg::PM_BUS_RNXT;
				end
				pm_pkg::PM_BUS_RNXT:
				begin
					if (link.scl_fall)
					begin
						next_r.cnt = '0;
						next_r.sda_drive = ~r.tx[15];
						next_r.bus_st = pm_pkg::PM_BUS_RD;
					end
				end
				default: next_r.bus_st = pm_pkg::PM_BUS_IDLE;
			endcase
		end

		if (wr_commit)
		begin
			if (r.byte_idx == 2'h0)
				next_r.ptr = r.shift;
			else if (r.byte_idx == 2'h1)
				next_r.msb = r.shift;
			else if (r.byte_idx == 2'h2)
				wd = {r.msb, r.shift};
			if (r.byte_idx != 2'h3)
				next_r.byte_idx = r.byte_idx + 2'h1;
		end

		// Registers stay writable in any conversion state
		// access in shutdown
		if (wr_commit && r.byte_idx == 2'h2)
		begin
			unique case (r.ptr)
				pm_pkg::REG_CONFIG:
				begin
					next_r.regs.config_reg = wd;
					soft_rst = wd[pm_pkg::CFG_RST_BIT];
				end
				pm_pkg::REG_ADC:
				begin
					next_r.regs.converter_setup_reg = wd;
					mode = wd[pm_pkg::MODE_LSB +: MODE_BITS];
					next_r.conv_start = (mode[2:0] != 3'h0);
					if (mode[2:0] == 3'h0)
						next_r.regs.conv_st = pm_pkg::PM_CONV_SHUT;
					else if (mode[pm_pkg::MODE_CONT_BIT])
						next_r.regs.conv_st = pm_pkg::PM_CONV_CONT;
					else
						next_r.regs.conv_st = pm_pkg::PM_CONV_TRIG;
				end
				pm_pkg::REG_DIAG:
				begin
					next_r.regs.alert_latch_en = wd[pm_pkg::DG_LATCH];
					next_r.regs.conv_ready_alert_en = wd[pm_pkg::DG_CONV_READY_ALERT_EN];
					next_r.regs.alert_on_averaged_sel = wd[pm_pkg::DG_SLOW];
					next_r.regs.alert_active_high_sel = wd[pm_pkg::DG_ALERT_ACTIVE_HIGH_SEL];
				end
				pm_pkg::REG_SHUNT_HIGH: next_r.regs.shunt_high_threshold = wd;
				pm_pkg::REG_SHUNT_LOW: next_r.regs.shunt_low_threshold = wd;
				pm_pkg::REG_BUS_HIGH: next_r.regs.bus_high_threshold = wd;
				pm_pkg::REG_BUS_LOW: next_r.regs.bus_low_threshold = wd;
				pm_pkg::REG_TEMP_LIMIT: next_r.regs.temp_threshold = wd;
				pm_pkg::REG_WATT_LIMIT: next_r.regs.wattage_threshold = wd;
				default: ;
			endcase
		end

		if (i_avg_done && r.regs.conv_st == pm_pkg::PM_CONV_TRIG)
			next_r.regs.conv_st = pm_pkg::PM_CONV_SHUT;

		// Clears first so that a same-cycle event wins
		// read releases latch
		if (diag_rd)
		begin
			next_r.regs.shunt_high_flag = 1'b0;
			next_r.regs.shunt_low_flag = 1'b0;
			next_r.regs.bus_high_flag = 1'b0;
			next_r.regs.bus_low_flag = 1'b0;
			next_r.regs.die_heat_flag = 1'b0;
			next_r.regs.power_over_limit_flag = 1'b0;
			next_r.regs.arith_overflow_flag = 1'b0;
		end
		if (diag_rd || next_r.conv_start)
			next_r.regs.conv_done_flag = 1'b0;
		if (i_avg_done)
			next_r.regs.conv_done_flag = 1'b1;
		if (i_arith_overflow)
			next_r.regs.arith_overflow_flag = 1'b1;

		if (cmp)
		begin
			if (!r.regs.alert_latch_en)
			begin
				next_r.regs.shunt_high_flag = hit_sh;
				next_r.regs.shunt_low_flag = hit_sl;
				next_r.regs.bus_high_flag = hit_bh;
				next_r.regs.bus_low_flag = hit_bl;
				next_r.regs.die_heat_flag = hit_t;
				next_r.regs.power_over_limit_flag = hit_p;
			end
			else
			begin
				next_r.regs.shunt_high_flag |= hit_sh;
				next_r.regs.shunt_low_flag |= hit_sl;
				next_r.regs.bus_high_flag |= hit_bh;
				next_r.regs.bus_low_flag |= hit_bl;
				next_r.regs.die_heat_flag |= hit_t;
				next_r.regs.power_over_limit_flag |= hit_p;
			end
		end

		if (soft_rst)
			next_r.regs = RST_REGS;

		// Overflow and trim status stay out of the alert
		// trim status excluded
		any_diag = next_r.regs.shunt_high_flag | next_r.regs.shunt_low_flag
			| next_r.regs.bus_high_flag | next_r.regs.bus_low_flag
			| next_r.regs.die_heat_flag | next_r.regs.power_over_limit_flag;
		active = any_diag | (next_r.regs.conv_ready_alert_en
			& next_r.regs.conv_done_flag);
		next_r.alert_drive = active ^ next_r.regs.alert_active_high_sel;
	end

	always_ff @(posedge i_clk_sys or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			r <= RST_STATE;
		else
			r <= next_r;
	end

	//**********************************************************
	// Outputs
	//**********************************************************
	assign o_scl_o = 1'b0;
	assign o_scl_oe_n = 1'b1;
	assign o_sda_o = 1'b0;
	assign o_sda_oe_n = ~r.sda_drive;
	assign o_alert_o = 1'b0;
	assign o_alert_oe_n = ~r.alert_drive;
	assign o_conv_start = r.conv_start;
	assign o_conv_active = (r.regs.conv_st != pm_pkg::PM_CONV_SHUT);
	assign o_conv_channels =
		r.regs.converter_setup_reg[pm_pkg::MODE_LSB +: 3];
endmodule // pm_top
`default_nettype wire

// *** pm_pkg.sv ***
package pm_pkg;
	// Register pointer values
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_ADC = 8'h01;
	localparam logic [7:0] REG_VSHUNT = 8'h04;
	localparam logic [7:0] REG_VBUS = 8'h05;
	localparam logic [7:0] REG_DIETEMP = 8'h06;
	localparam logic [7:0] REG_CURRENT = 8'h07;
	localparam logic [7:0] REG_POWER = 8'h08;
	localparam logic [7:0] REG_DIAG = 8'h0b;
	localparam logic [7:0] REG_SHUNT_HIGH = 8'h0c;
	localparam logic [7:0] REG_SHUNT_LOW = 8'h0d;
	localparam logic [7:0] REG_BUS_HIGH = 8'h0e;
	localparam logic [7:0] REG_BUS_LOW = 8'h0f;
	localparam logic [7:0] REG_TEMP_LIMIT = 8'h10;
	localparam logic [7:0] REG_WATT_LIMIT = 8'h11;
	localparam logic [7:0] REG_ID = 8'h3e;
	// Field positions
	localparam int CFG_RST_BIT = 15;
	localparam int MODE_LSB = 12;
	localparam int MODE_W = 4;
	localparam int MODE_CONT_BIT = 3;
	localparam int DG_LATCH = 15;
	localparam int DG_CONV_READY_ALERT_EN = 14;
	localparam int DG_SLOW = 13;
	localparam int DG_ALERT_ACTIVE_HIGH_SEL = 12;
	localparam int DG_ARITH_OVERFLOW_FLAG = 9;
	localparam int DG_TEMP = 7;
	localparam int DG_SHUNT_HI = 6;
	localparam int DG_SHUNT_LO = 5;
	localparam int DG_BUS_HI = 4;
	localparam int DG_BUS_LO = 3;
	localparam int DG_POWER = 2;
	localparam int DG_CONV_DONE_FLAG = 1;
	localparam int DG_MEMOK = 0;
	// Reset values
	localparam logic [15:0] RST_CONFIG = 16'h0000;
	localparam logic [15:0] RST_ADC = 16'hf000;
	localparam logic [15:0] RST_SHUNT_HIGH = 16'h7fff;
	localparam logic [15:0] RST_SHUNT_LOW = 16'h8000;
	localparam logic [15:0] RST_BUS_HIGH = 16'h7fff;
	localparam logic [15:0] RST_BUS_LOW = 16'h0000;
	localparam logic [15:0] RST_TEMP_LIMIT = 16'hffff;
	localparam logic [15:0] RST_WATT_LIMIT = 16'h7fff;
	// Bus address: fixed upper bits, then two pin codes
	localparam logic [2:0] ADDR_BASE = 3'h4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [1:0] {
		PM_CONV_SHUT = 2'b00,
		PM_CONV_TRIG = 2'b01,
		PM_CONV_CONT = 2'b10
	} pm_conv_e;
	typedef enum logic [2:0] {
		PM_BUS_IDLE = 3'b000,
		PM_BUS_ADDR = 3'b001,
		PM_BUS_WR = 3'b010,
		PM_BUS_ACK = 3'b011,
		PM_BUS_RD = 3'b100,
		PM_BUS_RACK = 3'b101,
		PM_BUS_RNXT = 3'b110
	} pm_bus_e;
endpackage

// *** pm_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pm_link_if;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	modport phy (output start, output stop, output scl_rise,
		output scl_fall, output sda);
	modport core (input start, input stop, input scl_rise,
		input scl_fall, input sda);
endinterface
`default_nettype wire

// *** pm_bus_phy.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_bus_phy
(
	input wire logic i_clk_sys,
	input wire logic i_rst_sync_b,
	input wire logic i_scl,
	input wire logic i_sda,
	pm_link_if.phy link
);
	typedef struct packed {
		logic scl_meta;
		logic sda_meta;
		logic scl_s;
		logic sda_s;
		logic scl_d;
		logic sda_d;
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} pm_phy_s;

	pm_phy_s r;
	pm_phy_s next_r;

	always_comb
	begin
		next_r = r;
		next_r.scl_meta = i_scl;
		next_r.sda_meta = i_sda;
		next_r.scl_s = r.scl_meta;
		next_r.sda_s = r.sda_meta;
		next_r.scl_d = r.scl_s;
		next_r.sda_d = r.sda_s;
		// SDA moving while SCL high marks start and stop
		next_r.start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
		next_r.stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
		next_r.rise = r.scl_s & ~r.scl_d;
		next_r.fall = ~r.scl_s & r.scl_d;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_sync_b)
	begin
		if (!i_rst_sync_b)
			r <= '{scl_meta: 1'b1, sda_meta: 1'b1, scl_s: 1'b1,
				sda_s: 1'b1, scl_d: 1'b1, sda_d: 1'b1, default: 1'b0};
		else
			r <= next_r;
	end

	assign link.start = r.start;
	assign link.stop = r.stop;
	assign link.scl_rise = r.rise;
	assign link.scl_fall = r.fall;
	assign link.sda = r.sda_d;
endmodule // pm_bus_phy
`default_nettype wire

// *** pm_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_chk
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_scl,
	input wire logic o_scl_oe_n,
	input wire logic o_sda_o,
	input wire logic o_sda_oe_n,
	input wire logic o_alert_o,
	input wire logic o_alert_oe_n,
	input wire logic i_sample_stb,
	input wire logic i_avg_done,
	input wire logic o_conv_start,
	input wire logic o_conv_active
);
	// ****
	// Cycles since a bus edge or a strobe
	// ****
	logic scl_q;
	logic [6:0] quiet;
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			scl_q <= 1'b1;
			quiet <= 7'h7f;
		end
		else
		begin
			scl_q <= i_scl;
			if (i_scl != scl_q || i_sample_stb || i_avg_done)
				quiet <= 7'h00;
			else if (quiet != 7'h7f)
				quiet <= quiet + 7'h01;
		end
	end
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	property p_scl_free;
		o_scl_oe_n;
	endproperty
	a_scl_free: assert property (p_scl_free)
		else $error("device drove the clock line");
	property p_open_drain;
		!o_sda_o && !o_alert_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain pin driven high");
	property p_sda_fall;
		$fell(o_sda_oe_n) |-> !i_scl;
	endproperty
	a_sda_fall: assert property (p_sda_fall)
		else $error("data pulled while clock high");
	property p_sda_rise;
		$rose(o_sda_oe_n) |-> !i_scl;
	endproperty
	a_sda_rise: assert property (p_sda_rise)
		else $error("data released while clock high");
	property p_alert_cause;
		!$stable(o_alert_oe_n) |-> quiet < 7'h40;
	endproperty
	a_alert_cause: assert property (p_alert_cause)
		else $error("alert moved without a cause");
	property p_rst_idle;
		$rose(i_rst_b) |-> o_alert_oe_n [*3];
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("alert not idle after reset");
	property p_start_act;
		o_conv_start |-> ##[0:1] o_conv_active;
	endproperty
	a_start_act: assert property (p_start_act)
		else $error("conversion request left device idle");
	property p_wake;
		$rose(o_conv_active) |-> o_conv_start || $past(o_conv_start);
	endproperty
	a_wake: assert property (p_wake)
		else $error("left shutdown without a request");
endmodule // pm_chk
`default_nettype wire

// *** pm_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module pm_host
(
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// ****
	// Host bus cycles, 125 ns bit time
	// ****
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic q(input logic c, input logic d);
		#31.25;
		o_scl = c;
		o_sda = d;
	endtask
	task automatic bit_io(input logic b, output logic r);
		q(1'b0, b);
		q(1'b1, b);
		q(1'b1, b);
		r = i_sda;
		q(1'b0, b);
	endtask
	task automatic start();
		q(o_scl, 1'b1);
		q(1'b1, 1'b1);
		q(1'b1, 1'b0);
		q(1'b0, 1'b0);
	endtask
	task automatic stop();
		q(1'b0, 1'b0);
		q(1'b1, 1'b0);
		q(1'b1, 1'b1);
	endtask
	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] q8, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r);
			q8[i] = r;
		end
		bit_io(last, r);
		ack = !r;
	endtask
	task automatic probe(input logic [6:0] a, output logic ok);
		logic [7:0] q8;
		start();
		xfer({a, 1'b0}, 1'b1, q8, ok);
		stop();
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p,
		input logic [15:0] v, output logic ok);
		logic [7:0] q8;
		logic k0, k1, k2, k3;
		start();
		xfer({a, 1'b0}, 1'b1, q8, k0);
		xfer(p, 1'b1, q8, k1);
		xfer(v[15:8], 1'b1, q8, k2);
		xfer(v[7:0], 1'b1, q8, k3);
		stop();
		ok = k0 & k1 & k2 & k3;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] p,
		output logic [15:0] v, output logic ok);
		logic [7:0] hi, lo;
		logic k0, k1, k2, kx;
		start();
		xfer({a, 1'b0}, 1'b1, hi, k0);
		xfer(p, 1'b1, hi, k1);
		start();
		xfer({a, 1'b1}, 1'b1, hi, k2);
		xfer(8'hff, 1'b0, hi, kx);
		xfer(8'hff, 1'b1, lo, kx);
		stop();
		v = {hi, lo};
		ok = k0 & k1 & k2;
	endtask
endmodule // pm_host
`default_nettype wire

// *** test_power_monitor_alert_and_bus_addressing.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_power_monitor_alert_and_bus_addressing;
	logic i_clk_sys, i_rst_b, h_scl, h_sda, ok;
	logic i_sample_stb, i_avg_done, i_arith_overflow, i_trim_ok;
	logic [1:0] i_addr_sel_high_pin, i_addr_sel_low_pin;
	logic [15:0] i_shunt, i_bus, i_temp, i_current, i_power, rv, s;
	logic o_scl_o, o_scl_oe_n, o_sda_o, o_sda_oe_n, o_alert_o, o_alert_oe_n;
	logic o_conv_start, o_conv_active;
	logic [2:0] o_conv_channels;
	logic [15:0] mdl [12:17];
	int mismatches, checked, starts, n;
	wire scl_w = h_scl & (o_scl_oe_n | o_scl_o);
	wire sda_w = h_sda & (o_sda_oe_n | o_sda_o);
	wire alert_w = o_alert_oe_n | o_alert_o;
	pm_host i_host (.i_sda(sda_w), .o_scl(h_scl), .o_sda(h_sda));
	pm_top i_dut (.i_clk_sys, .i_rst_b, .i_scl(scl_w), .o_scl_o, .o_scl_oe_n,
		.i_sda(sda_w), .o_sda_o, .o_sda_oe_n, .o_alert_o, .o_alert_oe_n,
		.i_addr_sel_high_pin, .i_addr_sel_low_pin, .i_sample_stb,
		.i_avg_done, .i_shunt, .i_bus, .i_temp, .i_current, .i_power,
		.i_arith_overflow, .i_trim_ok, .o_conv_start, .o_conv_active,
		.o_conv_channels);
	// ****
	// Checks, bus access and model
	// ****
	task automatic cmp_w(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_b(input string nm, input logic e, input logic g);
		cmp_w(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic put(input logic [7:0] p, input logic [15:0] v);
		i_host.wr({3'h4, i_addr_sel_high_pin, i_addr_sel_low_pin}, p, v, ok);
		cmp_b("write ack", 1'b1, ok);
	endtask
	task automatic get(input logic [7:0] p, output logic [15:0] v);
		i_host.rd({3'h4, i_addr_sel_high_pin, i_addr_sel_low_pin}, p, v, ok);
		cmp_b("read ack", 1'b1, ok);
	endtask
	task automatic sample(input logic a, input logic [15:0] sv,
		input logic [15:0] b);
		@(posedge i_clk_sys);
		i_shunt <= sv;
		i_bus <= b;
		i_current <= 16'($urandom);
		i_sample_stb <= !a;
		i_avg_done <= a;
		@(posedge i_clk_sys);
		i_sample_stb <= 1'b0;
		i_avg_done <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask
	task automatic chk_defaults();
		mdl = '{16'h7fff, 16'h8000, 16'h7fff, 16'h0000, 16'hffff, 16'h7fff};
		for (int r = 12; r <= 17; r++)
		begin
			get(r[7:0], rv);
			cmp_w("threshold", mdl[r], rv);
		end
	endtask
	function automatic logic [15:0] flags(input logic [15:0] sv,
		input logic [15:0] b);
		flags = 16'h0001;
		flags[pm_pkg::DG_SHUNT_HI] = $signed(sv) > $signed(mdl[12]);
		flags[pm_pkg::DG_SHUNT_LO] = $signed(sv) < $signed(mdl[13]);
		flags[pm_pkg::DG_BUS_HI] = $signed(b) > $signed(mdl[14]);
		flags[pm_pkg::DG_BUS_LO] = $signed(b) < $signed(mdl[15]);
	endfunction
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge i_clk_sys)
	begin
		if (o_conv_start === 1'b1)
			starts++;
	end
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	initial
	begin
		#450us;
		mismatches++;
		wrap_up();
	end
	// ****
	// Main sequence
	// ****
	initial
	begin
		{i_rst_b, i_sample_stb, i_avg_done, i_arith_overflow} = 4'h0;
		{i_addr_sel_high_pin, i_addr_sel_low_pin, i_trim_ok} = 5'h01;
		{i_shunt, i_bus, i_temp, i_current, i_power} = '0;
		void'($urandom(33));
		repeat (20) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		for (int k = 0; k < 16; k++)
		begin
			@(posedge i_clk_sys);
			{i_addr_sel_high_pin, i_addr_sel_low_pin} <= k[3:0];
			repeat (4) @(posedge i_clk_sys);
			i_host.probe({3'h4, k[3:0]}, ok);
			cmp_b("own address", 1'b1, ok);
			i_host.probe({3'h4, k[3:0]} ^ (7'h01 << $urandom_range(5)), ok);
			cmp_b("foreign address", 1'b0, ok);
		end
		$display("address test done");
		chk_defaults();
		$display("default test done");
		mdl[12] = 16'($urandom_range(16'h7000, 16'h1000));
		mdl[13] = -mdl[12];
		mdl[14] = 16'($urandom_range(16'h7000, 16'h2000));
		mdl[15] = 16'($urandom_range(16'h1000, 16'h0100));
		mdl[16] = 16'h7fff;
		for (int r = 12; r <= 16; r++)
			put(r[7:0], mdl[r]);
		for (int i = 0; i < 6; i++)
		begin
			s = (i == 0) ? mdl[12] + 16'h1 : (i == 1) ? mdl[12] : 16'($urandom);
			rv = 16'($urandom) & 16'h7fff;
			sample(1'b0, s, rv);
			cmp_b("alert pin", flags(s, rv) == 16'h0001, alert_w);
			get(pm_pkg::REG_DIAG, rv);
			cmp_w("diag", flags(s, i_bus), rv & 16'hfffd);
		end
		$display("compare test done");
		put(pm_pkg::REG_DIAG, 16'h8000);
		@(posedge i_clk_sys);
		i_arith_overflow <= 1'b1;
		@(posedge i_clk_sys);
		i_arith_overflow <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		cmp_b("alert pin", 1'b1, alert_w);
		sample(1'b0, mdl[12] + 16'h1, 16'h1800);
		sample(1'b0, 16'h0000, 16'h1800);
		cmp_b("alert pin", 1'b0, alert_w);
		get(pm_pkg::REG_DIAG, rv);
		cmp_w("diag", 16'h8241, rv & 16'hfffd);
		cmp_b("alert pin", 1'b1, alert_w);
		$display("latch test done");
		put(pm_pkg::REG_DIAG, 16'h0000);
		sample(1'b1, 16'h0000, 16'h1800);
		cmp_b("alert pin", 1'b1, alert_w);
		get(pm_pkg::REG_DIAG, rv);
		cmp_w("diag", 16'h0003, rv);
		get(pm_pkg::REG_DIAG, rv);
		cmp_w("diag", 16'h0001, rv);
		put(pm_pkg::REG_DIAG, 16'h4000);
		sample(1'b1, 16'h0000, 16'h1800);
		cmp_b("alert pin", 1'b0, alert_w);
		put(pm_pkg::REG_ADC, 16'hf000);
		get(pm_pkg::REG_DIAG, rv);
		cmp_w("diag", 16'h4001, rv);
		$display("ready test done");
		put(pm_pkg::REG_DIAG, 16'h1000);
		cmp_b("alert pin", 1'b0, alert_w);
		sample(1'b0, mdl[12] + 16'h1, 16'h1800);
		cmp_b("alert pin", 1'b1, alert_w);
		sample(1'b0, 16'h0000, 16'h1800);
		put(pm_pkg::REG_DIAG, 16'h2000);
		sample(1'b0, mdl[12] + 16'h1, 16'h1800);
		cmp_b("alert pin", 1'b1, alert_w);
		sample(1'b1, mdl[12] + 16'h1, 16'h1800);
		cmp_b("alert pin", 1'b0, alert_w);
		sample(1'b1, 16'h0000, 16'h1800);
		$display("polarity test done");
		put(pm_pkg::REG_ADC, 16'h0000);
		cmp_b("active", 1'b0, o_conv_active);
		put(pm_pkg::REG_WATT_LIMIT, 16'h1234);
		get(pm_pkg::REG_WATT_LIMIT, rv);
		cmp_w("limit", 16'h1234, rv);
		n = starts;
		put(pm_pkg::REG_ADC, 16'h7000);
		cmp_b("start pulse", 1'b1, starts == n + 1);
		cmp_b("active", 1'b1, o_conv_active);
		cmp_w("channels", 16'h0007, {13'h0000, o_conv_channels});
		sample(1'b1, 16'h0000, 16'h1800);
		cmp_b("active", 1'b0, o_conv_active);
		put(pm_pkg::REG_ADC, 16'hf000);
		put(pm_pkg::REG_CONFIG, 16'h8000);
		chk_defaults();
		cmp_b("active", 1'b1, o_conv_active);
		$display("mode test done");
		wrap_up();
	end
endmodule // test_power_monitor_alert_and_bus_addressing
bind pm_top pm_chk i_chk (.i_clk_sys, .i_rst_b, .i_scl, .o_scl_oe_n,
	.o_sda_o, .o_sda_oe_n, .o_alert_o, .o_alert_oe_n, .i_sample_stb,
	.i_avg_done, .o_conv_start, .o_conv_active);
`default_nettype wire
